// ==== verilog/ppg_fault_pkg.sv ====
`default_nettype none

package ppg_fault_pkg;

    localparam int          ADDR_W          = 6;
    localparam int          DATA_W          = 32;
    localparam int          CNT_W           = 8;

    // Byte addresses of the register words.
    localparam logic [5:0]  OFS_CTRL1       = 6'h00;
    localparam logic [5:0]  OFS_CTRL2       = 6'h04;
    localparam logic [5:0]  OFS_CTRL3       = 6'h08;
    localparam logic [5:0]  OFS_PERIOD      = 6'h0c;
    localparam logic [5:0]  OFS_DEAD        = 6'h10;
    localparam logic [5:0]  OFS_COUNT       = 6'h14;
    localparam logic [5:0]  OFS_IRQ_STATUS  = 6'h18;
    localparam logic [5:0]  OFS_IRQ_CLEAR   = 6'h1c;
    localparam logic [5:0]  OFS_IRQ_ENABLE  = 6'h20;

    // Control 1 fields.
    localparam int          B_INIT1         = 0;
    localparam int          B_INIT2         = 1;
    // Control 2 fields.
    localparam int          B_FAULT_IE      = 0;
    localparam int          B_OE1           = 1;
    localparam int          B_OE2           = 2;
    localparam int          B_PIN_INPUT     = 3;
    localparam int          B_RELEASE       = 7;
    // Control 3 fields.
    localparam int          B_START         = 0;
    localparam int          B_STOP_MODE_LO  = 1;
    localparam int          B_BUSY          = 6;
    localparam int          B_FLAG          = 7;
    // Interrupt status, clear and enable fields.
    localparam int          B_IRQ_FAULT     = 0;
    localparam int          B_IRQ_PERIOD    = 1;
    localparam int          IRQ_W           = 2;

    localparam logic [7:0]  CTRL1_RST       = 8'h00;
    localparam logic [7:0]  CTRL2_RST       = 8'h00;
    localparam logic [2:0]  CTRL3_RST       = 3'h0;
    localparam logic [7:0]  PERIOD_RST      = 8'hff;
    localparam logic [7:0]  DEAD_RST        = 8'h80;

    // Stop-mode field encodings.
    localparam logic [1:0]  STOP_CLEAR_INIT = 2'h0;
    localparam logic [1:0]  STOP_CLEAR_HOLD = 2'h1;
    localparam logic [1:0]  STOP_END_PERIOD = 2'h2;

    // Clock rate and fault response timing, in high-frequency clock periods.
    localparam int          CLK_HZ          = 100_000_000;
    localparam int          HF_CLK_HZ       = 100_000_000;
    localparam int          FAULT_MIN_LOW_CYC  = 4;
    localparam int          FAULT_RESPONSE_MAX = 10;
    localparam int          FAULT_RESPONSE_CYC = (FAULT_RESPONSE_MAX * (CLK_HZ / HF_CLK_HZ) > 0)
                                               ? FAULT_RESPONSE_MAX * (CLK_HZ / HF_CLK_HZ) : 1;
    localparam int          SYNC_STAGES     = 2;

    typedef enum logic [1:0] {TMR_IDLE, TMR_RUN, TMR_END_PERIOD} timer_state_t;

endpackage

`default_nettype wire

// ==== verilog/pulse_gen_if.sv ====
`default_nettype none

interface pulse_gen_if;
    import ppg_fault_pkg::*;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] dead;
    logic [1:0]       init_level;
    logic [1:0]       out_en;
    logic             run;
    logic             hold;
    logic             fault;
    logic [1:0]       pulse;

    modport ctrl (output count, dead, init_level, out_en, run, hold, fault, input pulse);
    modport gen  (input count, dead, init_level, out_en, run, hold, fault, output pulse);
endinterface

`default_nettype wire

// ==== verilog/fault_pin_sync.sv ====
`default_nettype none

module fault_pin_sync
    import ppg_fault_pkg::*;
(
    input  wire logic clk_sys,      // high-frequency clock
    input  wire logic arst_n,       // asynchronous reset
    input  wire logic fault_pin_n,  // raw fault pin
    output var  logic fault_low     // synchronised low level
);

    logic [SYNC_STAGES-1:0] sync_reg;

    // The pin is idle high, so the chain resets high.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sync_reg <= '1;
        end else begin
            sync_reg <= {sync_reg[SYNC_STAGES-2:0], fault_pin_n};
        end
    end

    assign fault_low = ~sync_reg[SYNC_STAGES-1];

endmodule

`default_nettype wire

// ==== verilog/pulse_out_gen.sv ====
`default_nettype none

module pulse_out_gen
    import ppg_fault_pkg::*;
(
    input  wire logic clk_sys,  // high-frequency clock
    input  wire logic arst_n,   // asynchronous reset
    pulse_gen_if.gen  pg        // waveform controls and outputs
);

    logic [1:0] pulse_reg;
    logic [1:0] pulse_next;
    logic       past_dead;

    assign past_dead = (pg.count >= pg.dead);

    // A disabled output sits at its initial level.
    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_out
            assign pulse_next[i] = (pg.fault || !pg.out_en[i]) ? pg.init_level[i] :
                                   pg.run  ? (pg.init_level[i] ^ past_dead) :
                                   pg.hold ? pulse_reg[i] : pg.init_level[i];
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pulse_reg <= 2'h0;
        end else begin
            pulse_reg <= pulse_next;
        end
    end

    assign pg.pulse = pulse_reg;

endmodule

`default_nettype wire

// ==== verilog/ppg_emergency_output_stop.sv ====
// Overview of operation
// - The fault pin is only heeded while the fault input enable bit is 1, which resets to 0.
// - A low level on the enabled fault pin forces both pulse outputs to their initial levels and raises the fault interrupt.
// - The fault stop disables only the outputs, and the counter keeps running until software stops it.
// - The fault pin counts only while its shared port pin is set to input mode.
// - The fault pin is sampled on the high-frequency clock.
// - Entering the fault stop sets a readable flag to 1 that shows the outputs are disabled.
// - Writing 1 to release bit 7 of control 2 cancels the stop only when start is 0 and stop mode is 00.
// - A cancel while the enabled pin is still low re-enters the stop and raises the interrupt again.
// - Each entry into the fault stop, and each re-entry on a cancel, raises the interrupt, whether or not the counter runs.
// - Start requests are refused while the fault stop is active.
// - The outputs reach their initial levels within ten clock periods of a low pin.
// - Entering a low-power mode initialises the timer and halts it.
// - The initial-level bit of each output selects its polarity.
`default_nettype none

module ppg_emergency_output_stop
    import ppg_fault_pkg::*;
(
    input  wire logic              clk_sys,          // 100 MHz high-frequency clock
    input  wire logic              arst_n,           // asynchronous reset, active low
    input  wire logic [ADDR_W-1:0] avs_address,      // byte address
    input  wire logic              avs_read,         // read request
    input  wire logic              avs_write,        // write request
    input  wire logic [DATA_W-1:0] avs_writedata,    // write data
    input  wire logic [3:0]        avs_byteenable,   // byte lanes
    output var  logic [DATA_W-1:0] avs_readdata,     // read data
    output logic                   avs_waitrequest,  // stall request
    input  wire logic              fault_pin_n,      // emergency fault pin, active low
    input  wire logic              low_power_mode,   // chip is in stop, slow or sleep mode
    output logic                   pulse_out1,       // first pulse output
    output logic                   pulse_out2,       // second pulse output
    output logic                   fault_stop_irq,   // level interrupt request
    output logic                   pulse_timer_busy  // counter is running
);

    pulse_gen_if pg ();

    logic [7:0]         ctrl1_reg;
    logic [7:0]         ctrl1_next;
    logic [3:0]         ctrl2_reg;
    logic [3:0]         ctrl2_next;
    logic               start_reg;
    logic               start_next;
    logic [1:0]         stop_mode_reg;
    logic [1:0]         stop_mode_next;
    logic [CNT_W-1:0]   period_reg;
    logic [CNT_W-1:0]   period_next;
    logic [CNT_W-1:0]   dead_reg;
    logic [CNT_W-1:0]   dead_next;
    logic [CNT_W-1:0]   count_reg;
    logic [CNT_W-1:0]   count_next;
    logic               flag_reg;
    logic               flag_next;
    logic               hold_reg;
    logic               hold_next;
    logic [IRQ_W-1:0]   status_reg;
    logic [IRQ_W-1:0]   status_next;
    logic [IRQ_W-1:0]   irq_en_reg;
    logic [IRQ_W-1:0]   irq_en_next;
    logic               ack_reg;
    logic [DATA_W-1:0]  rdata_reg;
    logic [DATA_W-1:0]  rdata_next;
    timer_state_t       state_reg;
    timer_state_t       state_next;

    logic               fault_low;
    logic               fault_accept;
    logic               fault_event;
    logic               req;
    logic               wr_take;
    logic               lane0;
    logic [7:0]         wbyte;
    logic               wr_ctrl1;
    logic               wr_ctrl2;
    logic               wr_ctrl3;
    logic               wr_period;
    logic               wr_dead;
    logic               wr_irq_clear;
    logic               wr_irq_en;
    logic               release_req;
    logic               release_ok;
    logic               start_req;
    logic               running;
    logic               period_end;
    logic [IRQ_W-1:0]   irq_events;
    logic [IRQ_W-1:0]   irq_clear;
    logic [7:0]         ctrl3_view;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] ofs);
        return a == ofs;
    endfunction

    function automatic logic [DATA_W-1:0] byte_word(input logic [7:0] b);
        return {{(DATA_W-8){1'b0}}, b};
    endfunction

    // Pin sampling on the high-frequency clock.
    fault_pin_sync u_sync (
        .clk_sys     (clk_sys),
        .arst_n      (arst_n),
        .fault_pin_n (fault_pin_n),
        .fault_low   (fault_low)
    );

    // Bus slave: every access is answered one cycle after it is raised.
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~ack_reg;
    assign wr_take         = avs_write & ack_reg;
    assign lane0           = avs_byteenable[0];
    assign wbyte           = avs_writedata[7:0];

    assign wr_ctrl1     = wr_take & lane0 & hit(avs_address, OFS_CTRL1);
    assign wr_ctrl2     = wr_take & lane0 & hit(avs_address, OFS_CTRL2);
    assign wr_ctrl3     = wr_take & lane0 & hit(avs_address, OFS_CTRL3);
    assign wr_period    = wr_take & lane0 & hit(avs_address, OFS_PERIOD);
    assign wr_dead      = wr_take & lane0 & hit(avs_address, OFS_DEAD);
    assign wr_irq_clear = wr_take & lane0 & hit(avs_address, OFS_IRQ_CLEAR);
    assign wr_irq_en    = wr_take & lane0 & hit(avs_address, OFS_IRQ_ENABLE);

    // Fault acceptance.
    assign fault_accept = fault_low & ctrl2_reg[B_FAULT_IE]
                        & ctrl2_reg[B_PIN_INPUT] & ~low_power_mode;
    assign release_req  = wr_ctrl2 & wbyte[B_RELEASE];
    assign release_ok   = release_req & ~start_reg & (stop_mode_reg == STOP_CLEAR_INIT);
    // A fresh entry, or a re-entry when a release meets a still-low pin.
    assign fault_event  = fault_accept & (~flag_reg | release_ok);

    assign flag_next = low_power_mode ? 1'b0 :
                       fault_accept   ? 1'b1 :
                       release_ok     ? 1'b0 : flag_reg;

    // Start requests are dropped while the stop is active.
    assign start_req  = wr_ctrl3 & wbyte[B_START] & ~flag_reg & ~fault_accept;
    assign start_next = low_power_mode ? 1'b0 :
                        wr_ctrl3 ? start_req : start_reg;
    assign stop_mode_next = low_power_mode ? 2'h0 :
                            wr_ctrl3 ? wbyte[B_STOP_MODE_LO +: 2] : stop_mode_reg;

    assign ctrl1_next  = low_power_mode ? CTRL1_RST :
                         wr_ctrl1 ? {6'h00, wbyte[B_INIT2], wbyte[B_INIT1]} : ctrl1_reg;
    assign ctrl2_next  = low_power_mode ? CTRL2_RST[3:0] :
                         wr_ctrl2 ? wbyte[3:0] : ctrl2_reg;
    assign period_next = low_power_mode ? PERIOD_RST : wr_period ? wbyte : period_reg;
    assign dead_next   = low_power_mode ? DEAD_RST : wr_dead ? wbyte : dead_reg;

    // Timer sequencing; the fault stop never halts the counter.
    assign running    = (state_reg != TMR_IDLE);
    assign period_end = running & (count_reg == period_reg);

    always_comb begin
        state_next = state_reg;
        hold_next  = hold_reg;
        case (state_reg)
            TMR_IDLE: begin
                if (start_reg) begin
                    state_next = TMR_RUN;
                    hold_next  = 1'b0;
                end
            end
            TMR_RUN: begin
                if (!start_reg) begin
                    case (stop_mode_reg)
                        STOP_CLEAR_INIT: begin
                            state_next = TMR_IDLE;
                            hold_next  = 1'b0;
                        end
                        STOP_CLEAR_HOLD: begin
                            state_next = TMR_IDLE;
                            hold_next  = 1'b1;
                        end
                        default: begin
                            state_next = TMR_END_PERIOD;
                        end
                    endcase
                end
            end
            TMR_END_PERIOD: begin
                if (period_end) begin
                    state_next = TMR_IDLE;
                    hold_next  = 1'b0;
                end
            end
            default: begin
                state_next = TMR_IDLE;
            end
        endcase
        if (low_power_mode) begin
            state_next = TMR_IDLE;
            hold_next  = 1'b0;
        end
    end

    always_comb begin
        if (low_power_mode || state_next == TMR_IDLE || state_reg == TMR_IDLE) begin
            count_next = '0;
        end else if (period_end) begin
            count_next = '0;
        end else begin
            count_next = count_reg + 8'h01;
        end
    end

    // Sticky interrupt status; a new event wins over a clear in the same cycle.
    assign irq_events  = {period_end, fault_event};
    assign irq_clear   = wr_irq_clear ? wbyte[IRQ_W-1:0] : '0;
    assign status_next = (status_reg & ~irq_clear) | irq_events;
    assign irq_en_next = wr_irq_en ? wbyte[IRQ_W-1:0] : irq_en_reg;

    // Read decode, captured the cycle the request is first seen.
    assign ctrl3_view = {flag_reg, running, 3'h0, stop_mode_reg, start_reg};

    always_comb begin
        rdata_next = '0;
        case (avs_address)
            OFS_CTRL1:      rdata_next = byte_word(ctrl1_reg);
            OFS_CTRL2:      rdata_next = byte_word({4'h0, ctrl2_reg});
            OFS_CTRL3:      rdata_next = byte_word(ctrl3_view);
            OFS_PERIOD:     rdata_next = byte_word(period_reg);
            OFS_DEAD:       rdata_next = byte_word(dead_reg);
            OFS_COUNT:      rdata_next = byte_word(count_reg);
            OFS_IRQ_STATUS: rdata_next = byte_word({6'h00, status_reg});
            OFS_IRQ_ENABLE: rdata_next = byte_word({6'h00, irq_en_reg});
            default:        rdata_next = '0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ack_reg   <= 1'b0;
            rdata_reg <= '0;
        end else begin
            ack_reg   <= req & ~ack_reg;
            rdata_reg <= (avs_read && !ack_reg) ? rdata_next : rdata_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl1_reg  <= CTRL1_RST;
            ctrl2_reg  <= CTRL2_RST[3:0];
            start_reg  <= CTRL3_RST[B_START];
            stop_mode_reg <= CTRL3_RST[B_STOP_MODE_LO +: 2];
            period_reg <= PERIOD_RST;
            dead_reg   <= DEAD_RST;
        end else begin
            ctrl1_reg  <= ctrl1_next;
            ctrl2_reg  <= ctrl2_next;
            start_reg  <= start_next;
            stop_mode_reg <= stop_mode_next;
            period_reg <= period_next;
            dead_reg   <= dead_next;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_reg  <= TMR_IDLE;
            count_reg  <= '0;
            hold_reg   <= 1'b0;
            flag_reg   <= 1'b0;
            status_reg <= '0;
            irq_en_reg <= '0;
        end else begin
            state_reg  <= state_next;
            count_reg  <= count_next;
            hold_reg   <= hold_next;
            flag_reg   <= flag_next;
            status_reg <= status_next;
            irq_en_reg <= irq_en_next;
        end
    end

    // Waveform stage; the accepted fault forces outputs on the very next edge.
    assign pg.count      = count_reg;
    assign pg.dead       = dead_reg;
    assign pg.init_level = {ctrl1_reg[B_INIT2], ctrl1_reg[B_INIT1]};
    assign pg.out_en     = {ctrl2_reg[B_OE2], ctrl2_reg[B_OE1]};
    assign pg.run        = running;
    assign pg.hold       = hold_reg;
    assign pg.fault      = flag_reg | fault_accept;

    pulse_out_gen u_gen (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .pg      (pg.gen)
    );

    assign pulse_out1       = pg.pulse[0];
    assign pulse_out2       = pg.pulse[1];
    assign fault_stop_irq   = |(status_reg & irq_en_reg);
    assign pulse_timer_busy = running;
    assign avs_readdata     = rdata_reg;

endmodule

`default_nettype wire

// ==== testbench/fault_source.sv ====
`default_nettype none

module fault_source
    import ppg_fault_pkg::*;
(
    input  wire logic       clk_sys,     // system clock
    input  wire logic       arst_n,      // asynchronous reset, active low
    input  wire logic       fire,        // one-cycle request for a low pulse
    input  wire logic [7:0] low_len,     // requested low length in cycles
    output var  logic       fault_pin_n  // fault pin, high when idle
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] left_reg;

    // Short requests are stretched so the pin is never low for under the minimum.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            left_reg <= 8'h00;
        end else if (fire) begin
            left_reg <= (low_len < 8'(FAULT_MIN_LOW_CYC)) ? 8'(FAULT_MIN_LOW_CYC) : low_len;
        end else if (left_reg != 8'h00) begin
            left_reg <= left_reg - 8'h01;
        end
    end

    assign fault_pin_n = (left_reg == 8'h00);
endmodule

`default_nettype wire

// ==== testbench/ppg_fault_asserts.sv ====
`default_nettype none

module ppg_fault_asserts
    import ppg_fault_pkg::*;
(
    input wire logic              clk_sys,          // clock
    input wire logic              arst_n,           // reset
    input wire logic [ADDR_W-1:0] avs_address,      // address
    input wire logic              avs_read,         // read
    input wire logic              avs_write,        // write
    input wire logic [DATA_W-1:0] avs_writedata,    // write data
    input wire logic [3:0]        avs_byteenable,   // lanes
    input wire logic [DATA_W-1:0] avs_readdata,     // read data
    input wire logic              avs_waitrequest,  // stall
    input wire logic              fault_pin_n,      // fault pin
    input wire logic              low_power_mode,   // low power
    input wire logic              pulse_out1,       // output 1
    input wire logic              pulse_out2,       // output 2
    input wire logic              fault_stop_irq,   // interrupt
    input wire logic              pulse_timer_busy  // running
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] init_sh;
    logic [1:0] en_sh;
    logic       ie_sh;
    logic       pin_sh;
    logic       stopped_sh;
    logic [1:0] low_cnt;
    wire  logic wdone   = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire  logic w_ctrl2 = wdone && (avs_address == OFS_CTRL2);
    wire  logic cond    = !fault_pin_n && ie_sh && pin_sh && !low_power_mode;

    // Shadow of the control bits that decide whether a fault is accepted, plus initial levels, interrupt enables and fault-stop state.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            init_sh    <= 2'h0;
            en_sh      <= 2'h0;
            ie_sh      <= 1'b0;
            pin_sh     <= 1'b0;
            stopped_sh <= 1'b0;
            low_cnt    <= 2'h0;
        end else begin
            if (low_power_mode) begin
                init_sh <= 2'h0;
                ie_sh   <= 1'b0;
                pin_sh  <= 1'b0;
            end else if (wdone && avs_address == OFS_CTRL1) begin
                init_sh <= avs_writedata[1:0];
            end else if (w_ctrl2) begin
                ie_sh  <= avs_writedata[B_FAULT_IE];
                pin_sh <= avs_writedata[B_PIN_INPUT];
            end
            if (wdone && avs_address == OFS_IRQ_ENABLE) begin
                en_sh <= avs_writedata[1:0];
            end
            low_cnt <= !cond ? 2'h0 : (low_cnt == 2'h3) ? 2'h3 : low_cnt + 2'h1;
            if (low_power_mode || (w_ctrl2 && avs_writedata[B_RELEASE] && fault_pin_n)) begin
                stopped_sh <= 1'b0;
            end else if (cond && low_cnt == 2'h2) begin
                stopped_sh <= 1'b1;
            end
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    a_wait_one_cycle: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest) else $error("waitrequest held too long");
    a_read_upper_zero: assert property (avs_read && !avs_waitrequest
        |-> avs_readdata[31:8] == 24'h0) else $error("read data upper bits set");
    a_forced_init_level: assert property (cond [*4]
        |-> ##[0:6] ({pulse_out2, pulse_out1} == init_sh)) else $error("outputs not forced");
    a_irq_on_fault: assert property ((cond && en_sh[B_IRQ_FAULT]) [*4]
        |-> ##[0:6] fault_stop_irq) else $error("fault interrupt missing");
    a_irq_gated_enable: assert property ($rose(fault_stop_irq) && $stable(en_sh)
        && !en_sh[B_IRQ_PERIOD] |-> $past(ie_sh && pin_sh && !low_power_mode))
        else $error("fault accepted while disabled");
    a_low_power_halt: assert property (low_power_mode |=> !pulse_timer_busy)
        else $error("timer runs in low power");
    a_no_restart: assert property (stopped_sh && !pulse_timer_busy
        |=> !pulse_timer_busy) else $error("timer restarted during fault");
    a_count_kept: assert property ($rose(stopped_sh) && pulse_timer_busy
        |=> pulse_timer_busy) else $error("counter stopped by fault");
endmodule

bind ppg_emergency_output_stop ppg_fault_asserts ppg_fault_asserts_inst (
    .clk_sys, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .fault_pin_n, .low_power_mode,
    .pulse_out1, .pulse_out2, .fault_stop_irq, .pulse_timer_busy);

`default_nettype wire

// ==== testbench/test_ppg_emergency_output_stop.sv ====
`default_nettype none

module test_ppg_emergency_output_stop;
    timeunit 1ns;
    timeprecision 1ps;
    import ppg_fault_pkg::*;

    logic              clk_sys, arst_n, avs_read, avs_write, fire, low_power_mode;
    logic [ADDR_W-1:0] avs_address;
    logic [DATA_W-1:0] avs_writedata, avs_readdata;
    logic [3:0]        avs_byteenable;
    logic [7:0]        low_len;
    logic              avs_waitrequest, fault_pin_n, pulse_out1, pulse_out2;
    logic              fault_stop_irq, pulse_timer_busy;
    int                n_mismatch, num_checks;

    ppg_emergency_output_stop ppg_emergency_output_stop_inst (.clk_sys, .arst_n,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .fault_pin_n, .low_power_mode, .pulse_out1,
        .pulse_out2, .fault_stop_irq, .pulse_timer_busy);
    fault_source fault_source_inst (.clk_sys, .arst_n, .fire, .low_len, .fault_pin_n);

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic cmp1(input string n, input logic e, input logic s);
        num_checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %b seen %b", n, e, s);
        end
    endtask

    // One bus cycle, held until waitrequest is seen low at a rising edge.
    task automatic acc(input logic [5:0] a, input logic w, input logic [7:0] d,
                       output logic [7:0] q);
        avs_address   <= a;
        avs_writedata <= {24'h0, d};
        avs_write     <= w;
        avs_read      <= !w;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(a, 1'b1, d, q);
    endtask

    task automatic rdc(input logic [5:0] a, input logic [7:0] e);
        logic [7:0] q;
        acc(a, 1'b0, 8'h00, q);
        cmp8($sformatf("reg %h", a), e, q);
    endtask

    task automatic fault(input int len);
        low_len <= 8'(len);
        fire    <= 1'b1;
        tick(1);
        fire    <= 1'b0;
        tick(len + 4);
    endtask

    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        tick(20000);
        n_mismatch++;
        $display("watchdog expired");
        print_verdict();
    end

    initial begin
        {arst_n, avs_read, avs_write, fire, low_power_mode} = 5'h0;
        avs_address = '0;
        avs_writedata = '0;
        avs_byteenable = 4'h1;
        low_len = 8'h00;
        n_mismatch = 0;
        num_checks = 0;
        tick(4);
        arst_n <= 1'b1;
        tick(1);
        rdc(OFS_CTRL1, 8'h00);
        rdc(OFS_CTRL2, 8'h00);
        rdc(OFS_CTRL3, 8'h00);
        rdc(OFS_PERIOD, 8'hff);
        rdc(OFS_DEAD, 8'h80);
        rdc(OFS_IRQ_ENABLE, 8'h00);
        wr(6'h24, 8'h5a);
        rdc(6'h24, 8'h00);
        wr(OFS_COUNT, 8'h33);
        rdc(OFS_COUNT, 8'h00);
        done("reset");
        wr(OFS_IRQ_ENABLE, 8'h01);
        wr(OFS_CTRL2, 8'h08);
        fault(6);
        rdc(OFS_CTRL3, 8'h00);
        wr(OFS_CTRL2, 8'h01);
        fault(6);
        rdc(OFS_IRQ_STATUS, 8'h00);
        done("gating");
        wr(OFS_CTRL1, 8'h01);
        wr(OFS_DEAD, 8'h00);
        wr(OFS_CTRL2, 8'h0f);
        wr(OFS_CTRL3, 8'h01);
        tick(3);
        cmp1("pulse_out1", 1'b0, pulse_out1);
        cmp1("pulse_out2", 1'b1, pulse_out2);
        fault(2);
        cmp1("pulse_out1", 1'b1, pulse_out1);
        cmp1("pulse_out2", 1'b0, pulse_out2);
        cmp1("fault_stop_irq", 1'b1, fault_stop_irq);
        cmp1("pulse_timer_busy", 1'b1, pulse_timer_busy);
        rdc(OFS_CTRL3, 8'hc1);
        done("fault");
        wr(OFS_CTRL2, 8'h8f);
        rdc(OFS_CTRL3, 8'hc1);
        wr(OFS_CTRL3, 8'h02);
        wr(OFS_CTRL2, 8'h8f);
        rdc(OFS_CTRL3, 8'h82);
        wr(OFS_CTRL3, 8'h03);
        rdc(OFS_CTRL3, 8'h82);
        wr(OFS_CTRL3, 8'h00);
        wr(OFS_CTRL3, 8'h01);
        rdc(OFS_CTRL3, 8'h80);
        cmp1("pulse_timer_busy", 1'b0, pulse_timer_busy);
        done("refusals");
        low_len <= 8'd40;
        fire    <= 1'b1;
        tick(1);
        fire    <= 1'b0;
        tick(8);
        wr(OFS_IRQ_CLEAR, 8'h01);
        wr(OFS_CTRL2, 8'h8f);
        rdc(OFS_CTRL3, 8'h80);
        cmp1("fault_stop_irq", 1'b1, fault_stop_irq);
        tick(40);
        wr(OFS_IRQ_CLEAR, 8'h01);
        rdc(OFS_IRQ_STATUS, 8'h00);
        wr(OFS_CTRL2, 8'h8f);
        rdc(OFS_CTRL3, 8'h00);
        rdc(OFS_CTRL2, 8'h0f);
        cmp1("fault_stop_irq", 1'b0, fault_stop_irq);
        done("release");
        wr(OFS_IRQ_ENABLE, 8'h00);
        fault(5);
        cmp1("fault_stop_irq", 1'b0, fault_stop_irq);
        rdc(OFS_IRQ_STATUS, 8'h01);
        rdc(OFS_CTRL3, 8'h80);
        wr(OFS_IRQ_ENABLE, 8'h01);
        cmp1("fault_stop_irq", 1'b1, fault_stop_irq);
        wr(OFS_IRQ_CLEAR, 8'h01);
        cmp1("fault_stop_irq", 1'b0, fault_stop_irq);
        done("interrupt");
        wr(OFS_CTRL2, 8'h8f);
        wr(OFS_CTRL3, 8'h01);
        tick(2);
        cmp1("pulse_timer_busy", 1'b1, pulse_timer_busy);
        low_power_mode <= 1'b1;
        tick(2);
        low_power_mode <= 1'b0;
        tick(1);
        cmp1("pulse_timer_busy", 1'b0, pulse_timer_busy);
        rdc(OFS_CTRL3, 8'h00);
        rdc(OFS_CTRL2, 8'h00);
        rdc(OFS_CTRL1, 8'h00);
        rdc(OFS_IRQ_ENABLE, 8'h01);
        wr(OFS_CTRL1, 8'h02);
        rdc(OFS_CTRL1, 8'h02);
        done("low power");
        print_verdict();
    end
endmodule

`default_nettype wire
